// >>> hdl/cad_decoder.sv
`timescale 1ns/10ps
`include "cad_defines.svh"
module cad_decoder
  import cad_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // program memory, read combinationally
  output logic [11:0] pm_addr,
  input wire logic [7:0] pm_rdata,
  // data memory, read combinationally
  output logic [7:0] dm_addr,
  input wire logic [7:0] dm_rdata,
  output logic [7:0] dm_wdata,
  output logic dm_we,
  // interrupt entry
  input wire logic int_req,
  input wire logic [11:0] int_vector,
  output logic int_ack,
  // to execution stage
  output cad_dec_s dec,
  output logic dec_valid,
  output logic [11:0] pc,
  output logic [7:0] acc,
  output logic zf,
  output logic cf
);

  // ==========================================
  // opcode decode
  // opcode groups
  function automatic cad_info_s decode(input logic [7:0] op);
    cad_info_s i;
    i = '{mode: m_inh, group: g_ctrl, kind: k_ill, len: `CAD_LEN1, ncyc: `CAD_CYC_CTRL};
    if (!op[7]) begin
      i = '{mode: m_rel, group: g_branch, kind: k_jr, len: `CAD_LEN1, ncyc: `CAD_CYC_REL};
    end else if (op[7:5] == 3'b100) begin
      i = '{mode: m_ext, group: g_jump, kind: (op[4] ? k_call : k_jp),
            len: `CAD_LEN2, ncyc: `CAD_CYC_EXT};
    end else if (op[7:4] == 4'ha) begin
      i = '{mode: m_bitdir, group: g_bit, kind: k_bitop, len: `CAD_LEN2, ncyc: `CAD_CYC_BIT};
    end else if (op[7:4] == 4'hb) begin
      i = '{mode: m_bittst, group: g_branch, kind: k_btst, len: `CAD_LEN3,
            ncyc: `CAD_CYC_BTST};
    end else if (op[7:3] == 5'b11000) begin
      i = '{mode: m_short, group: g_ldst, kind: (op[2] ? k_st : k_ld_a), len: `CAD_LEN1,
            ncyc: `CAD_CYC_LDST};
    end else if (op[7:5] == 3'b110 && op[3] && op[1:0] == 2'b00) begin
      i = '{mode: m_ind, group: g_ldst, kind: (op[2] ? k_st : k_ld_a), len: `CAD_LEN1,
            ncyc: `CAD_CYC_LDST};
    end else if (op[7:1] == 7'b1110000) begin
      i = '{mode: m_dir, group: g_ldst, kind: (op[0] ? k_st : k_ld_a), len: `CAD_LEN2,
            ncyc: `CAD_CYC_LDST};
    end else if (op == 8'he2) begin
      i = '{mode: m_imm, group: g_ldst, kind: k_ldc_a, len: `CAD_LEN2, ncyc: `CAD_CYC_LDST};
    end else if (op == 8'he3) begin
      i = '{mode: m_imm, group: g_ldst, kind: k_ldc_m, len: `CAD_LEN3, ncyc: `CAD_CYC_LDST};
    end else if (op[7:4] == 4'hf) begin
      case (op[3:0])
        4'h0: i.kind = k_nop;
        4'h1: i.kind = k_ret;
        4'h2: i.kind = k_reti;
        4'h3: i.kind = k_wait;
        4'h4: i.kind = k_stop;
        default: i.kind = k_ill;
      endcase
    end
    return i;
  endfunction : decode

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction : bit_mask

  // ==========================================
  // state
  logic [7:0] op_r, b1_r, b2_r, ptr_r, dat_r, acc_r, acc_nxt;
  logic zf_r, cf_r, zf_nxt, cf_nxt, dec_valid_r, int_ack_r, commit, taken;
  logic [11:0] pc_r, pc_nxt, stk_top;
  logic [2:0] cyc_r, sp_r;
  logic [11:0] stk_r [0:5];
  logic [7:0] ea, bm;
  logic bitval;
  cad_dec_s dec_r;
  cad_info_s info;

  assign info = decode(op_r);
  assign commit = ce && cyc_r != 3'd0 && cyc_r == info.ncyc - 3'd1;
  assign bm = bit_mask(op_r[2:0]);
  assign bitval = |(dat_r & bm);
  assign stk_top = (sp_r != 3'd0) ? stk_r[sp_r - 3'd1] : 12'h000;

  // ==========================================
  // operand addressing
  // direct, bit direct address from next byte
  // short direct picks 80h..83h, indirect uses pointer
  assign ea = (info.mode == m_short) ? (`CAD_WREG_BASE | {6'h00, op_r[1:0]}) :
              (info.mode == m_ind) ? ptr_r :
              (info.mode == m_dir || info.mode == m_bitdir || info.mode == m_bittst ||
               info.kind == k_ldc_m) ? b1_r : 8'h00;
  // pointer fetched at 80h or 81h by opcode bit 4
  assign dm_addr = (cyc_r == 3'd1 && info.mode == m_ind) ?
                   (`CAD_PTR_BASE | {7'h00, op_r[4]}) : ea;
  assign pm_addr = pc_r + {9'h000, cyc_r};
  assign dm_we = commit && (info.kind == k_st || info.kind == k_ldc_m || info.kind == k_bitop);
  assign dm_wdata = (info.kind == k_st) ? acc_r :
                    (info.kind == k_ldc_m) ? b2_r :
                    (op_r[3] ? (dat_r | bm) : (dat_r & ~bm));

  // ==========================================
  // flags and accumulator
  // loads and stores update zero only; constant store touches nothing
  // immediate value taken from byte after opcode
  assign acc_nxt = (info.kind == k_ld_a) ? dat_r : (info.kind == k_ldc_a) ? b1_r : acc_r;
  assign zf_nxt = (info.kind == k_ld_a || info.kind == k_ldc_a) ? (acc_nxt == 8'h00) :
                  (info.kind == k_st) ? (acc_r == 8'h00) : zf_r;
  assign cf_nxt = (info.kind == k_bitop || info.kind == k_btst) ? bitval : cf_r;

  // ==========================================
  // next program counter
  // test from op[6:5], direction op[4], span op[3:0]
  assign taken = (info.kind == k_jr) ?
                 (op_r[6:5] == 2'b00 ? !zf_r : op_r[6:5] == 2'b01 ? zf_r :
                  op_r[6:5] == 2'b10 ? !cf_r : cf_r) :
                 (bitval == op_r[3]);
  // forward +1..+16, backward 0..-15, else next instruction
  // extended target, signed displacement from pc+1
  assign pc_nxt = (info.kind == k_jr && taken) ?
                  (op_r[4] ? pc_r - {8'h00, op_r[3:0]} : pc_r + 12'h001 + {8'h00, op_r[3:0]}) :
                  (info.kind == k_jp || info.kind == k_call) ? {op_r[3:0], b1_r} :
                  (info.kind == k_btst && taken) ?
                  pc_r + 12'h001 + {{4{b2_r[7]}}, b2_r} :
                  (info.kind == k_ret || info.kind == k_reti) ? stk_top :
                  pc_r + {10'h000, info.len};

  // ==========================================
  // sequencer
  // result published at commit, and pc loads pc_nxt on the same edge
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      op_r <= 8'hf0;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      ptr_r <= 8'h00;
      dat_r <= 8'h00;
      acc_r <= 8'h00;
      zf_r <= 1'b0;
      cf_r <= 1'b0;
      pc_r <= 12'h000;
      cyc_r <= 3'd0;
      sp_r <= 3'd0;
      dec_r <= '0;
      dec_valid_r <= 1'b0;
      int_ack_r <= 1'b0;
      for (int k = 0; k < 6; k++) begin
        stk_r[k] <= 12'h000;
      end
    end else if (ce) begin
      dec_valid_r <= 1'b0;
      int_ack_r <= 1'b0;
      if (cyc_r == 3'd0) begin
        if (int_req) begin
          // interrupt return address pushed; full stack drops it
          if (sp_r != `CAD_STACK_DEPTH) begin
            stk_r[sp_r] <= pc_r;
            sp_r <= sp_r + 3'd1;
          end
          pc_r <= int_vector;
          int_ack_r <= 1'b1;
        end else begin
          op_r <= pm_rdata;
          cyc_r <= 3'd1;
        end
      end else if (commit) begin
        cyc_r <= 3'd0;
        pc_r <= pc_nxt;
        acc_r <= acc_nxt;
        zf_r <= zf_nxt;
        cf_r <= cf_nxt;
        dec_r <= '{mode: info.mode, group: info.group, len: info.len, addr: ea};
        dec_valid_r <= 1'b1;
        if (info.kind == k_call && sp_r != `CAD_STACK_DEPTH) begin
          stk_r[sp_r] <= pc_r + 12'h002;
          sp_r <= sp_r + 3'd1;
        end else if ((info.kind == k_ret || info.kind == k_reti) && sp_r != 3'd0) begin
          sp_r <= sp_r - 3'd1;
        end
      end else begin
        cyc_r <= cyc_r + 3'd1;
        if (cyc_r == 3'd1) begin
          b1_r <= pm_rdata;
          ptr_r <= dm_rdata;
        end
        if (cyc_r == 3'd2) begin
          b2_r <= pm_rdata;
          dat_r <= dm_rdata;
        end
      end
    end
  end

  assign dec = dec_r;
  assign dec_valid = dec_valid_r;
  assign int_ack = int_ack_r;
  assign pc = pc_r;
  assign acc = acc_r;
  assign zf = zf_r;
  assign cf = cf_r;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_ldst_cycles: assert property (commit && info.group == g_ldst |-> cyc_r == 3'd3)
    else $error("load/store not four cycles");
  chk_ldst_carry: assert property (commit && info.group == g_ldst |=> $stable(cf_r))
    else $error("load/store changed carry");
  chk_ldc_flags: assert property (commit && info.kind == k_ldc_m |=> $stable({zf_r, cf_r}))
    else $error("constant store changed flags");
  chk_bit_carry: assert property (commit && info.kind == k_bitop |=> cf_r == $past(bitval))
    else $error("carry not loaded with bit");
  chk_imm_value: assert property (commit && info.kind == k_ldc_a |=> acc_r == b1_r)
    else $error("immediate operand wrong");
  chk_short_addr: assert property (dec_valid_r && dec_r.mode == m_short |->
    dec_r.addr[7:2] == 6'h20 && dec_r.len == `CAD_LEN1)
    else $error("short direct address out of 80h..83h");
  chk_ext_target: assert property (commit && info.kind == k_jp |=>
    pc_r == {$past(op_r[3:0]), $past(b1_r)})
    else $error("extended target wrong");
  chk_rel_fall: assert property (commit && info.kind == k_jr && !taken |=>
    pc_r == $past(pc_r) + 12'h001)
    else $error("untaken branch not sequential");
  chk_stack_depth: assert property (sp_r <= `CAD_STACK_DEPTH)
    else $error("stack pointer beyond six");
  chk_inh_len: assert property (dec_valid_r && dec_r.mode == m_inh |-> dec_r.len == `CAD_LEN1)
    else $error("inherent longer than one byte");
  chk_ind_ptr: assert property (ce && cyc_r == 3'd1 && info.mode == m_ind |->
    dm_addr == {7'h40, op_r[4]})
    else $error("indirect pointer address wrong");

  cov_call_ret: cover property (commit && info.kind == k_call ##[1:40] commit && info.kind == k_ret);
  cov_btst_taken: cover property (commit && info.kind == k_btst && taken);
  cov_int_entry: cover property (int_ack_r);
  cov_rel_fall: cover property (commit && info.kind == k_jr && !taken);

endmodule : cad_decoder

// >>> hdl/cad_defines.svh
`ifndef CAD_DEFINES_SVH
`define CAD_DEFINES_SVH

// ==========================================
// data space locations
`define CAD_WREG_BASE 8'h80
`define CAD_PTR_BASE 8'h80

// ==========================================
// instruction lengths in bytes
`define CAD_LEN1 2'd1
`define CAD_LEN2 2'd2
`define CAD_LEN3 2'd3

// ==========================================
// cycles per instruction
`define CAD_CYC_LDST 3'd4
`define CAD_CYC_REL 3'd2
`define CAD_CYC_BTST 3'd5
`define CAD_CYC_BIT 3'd4
`define CAD_CYC_EXT 3'd4
`define CAD_CYC_CTRL 3'd2

// ==========================================
// return stack
`define CAD_STACK_DEPTH 3'd6

`endif

// >>> hdl/cad_pkg.sv
package cad_pkg;

  // ==========================================
  // addressing modes and groups
  typedef enum logic [3:0] {
    m_imm, m_dir, m_short, m_ext, m_rel, m_bitdir, m_bittst, m_ind, m_inh
  } cad_mode_e;

  typedef enum logic [2:0] {
    g_ldst, g_alu, g_branch, g_ctrl, g_jump, g_bit
  } cad_group_e;

  typedef enum logic [3:0] {
    k_nop, k_ld_a, k_st, k_ldc_a, k_ldc_m, k_jp, k_call, k_jr,
    k_bitop, k_btst, k_ret, k_reti, k_wait, k_stop, k_ill
  } cad_kind_e;

  // ==========================================
  // decoded opcode and decoder result
  typedef struct packed {
    cad_mode_e mode;
    cad_group_e group;
    cad_kind_e kind;
    logic [1:0] len;
    logic [2:0] ncyc;
  } cad_info_s;

  typedef struct packed {
    cad_mode_e mode;
    cad_group_e group;
    logic [1:0] len;
    logic [7:0] addr;
  } cad_dec_s;

endpackage : cad_pkg

// >>> verif/cad_mem_model.sv
`timescale 1ns/10ps
// ==========================================
// program and data memory seen by the core
module cad_mem_model (
  // clock
  input wire logic ref_clk,
  // program side
  input wire logic [11:0] pm_addr,
  output logic [7:0] pm_rdata,
  // data side
  input wire logic [7:0] dm_addr,
  output logic [7:0] dm_rdata,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we
);
  logic [7:0] pmem [4096];
  logic [7:0] dmem [256];

  // same-cycle answer: the core has no wait state to offer
  assign pm_rdata = pmem[pm_addr];
  assign dm_rdata = dmem[dm_addr];

  always @(posedge ref_clk) begin
    if (dm_we === 1'b1) begin
      dmem[dm_addr] <= dm_wdata;
    end
  end
endmodule : cad_mem_model

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import cad_pkg::*;
  typedef struct packed {
    logic [11:0] pc;
    logic [7:0] acc;
    logic zf;
    logic cf;
    logic [1:0] len;
    cad_mode_e mode;
    logic [7:0] addr;
    logic ca;
    logic [2:0] nc;
  } cad_exp_s;

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b0;
  logic int_req = 1'b0;
  logic [11:0] int_vector = 12'h300;
  logic [11:0] pm_addr;
  logic [7:0] pm_rdata, dm_addr, dm_rdata, dm_wdata, acc;
  logic dm_we, int_ack, dec_valid, zf, cf;
  logic [11:0] pc;
  cad_dec_s dec;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int acnt = 0;
  int acks = 0;
  logic ce_q = 1'b0;
  logic run = 1'b0;
  cad_exp_s expq [$];
  cad_exp_s e;
  logic [7:0] n, q, d, a;
  logic [2:0] b;
  logic [11:0] p, wp;
  logic z, c;

  always #20 ref_clk = ~ref_clk;

  cad_decoder dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack),
    .dec(dec), .dec_valid(dec_valid), .pc(pc), .acc(acc), .zf(zf), .cf(cf));
  cad_mem_model mem (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));

  // ==========================================
  // helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // group follows from the addressing mode for the opcodes used here
  function automatic cad_group_e exp_group(input cad_mode_e m);
    if (m == m_rel || m == m_bittst) begin
      return g_branch;
    end else if (m == m_ext) begin
      return g_jump;
    end else if (m == m_bitdir) begin
      return g_bit;
    end else if (m == m_inh) begin
      return g_ctrl;
    end
    return g_ldst;
  endfunction : exp_group

  task automatic emit(input logic [7:0] v);
    mem.pmem[wp] = v;
    wp = wp + 12'h001;
  endtask : emit

  task automatic note(input logic [1:0] len, input cad_mode_e mode, input logic [7:0] ad,
      input logic ca, input logic [2:0] nc);
    expq.push_back(cad_exp_s'{p, a, z, c, len, mode, ad, ca, nc});
  endtask : note

  // ==========================================
  // watcher: one note per finished instruction
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      mismatches++;
      complete_run();
    end
    ce_q <= ce;
    // stalls freeze outputs, so only count edges that really ran
    if (ce_q) begin
      acnt = acnt + 1;
    end
    if (ce_q && int_ack === 1'b1) begin
      acks++;
    end
    if (ce_q && dec_valid === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      check(64'(pc), 64'(e.pc));
      check(64'({acc, zf, cf}), 64'({e.acc, e.zf, e.cf}));
      check(64'({dec.mode, dec.len}), 64'({e.mode, e.len}));
      check(64'(dec.group), 64'(exp_group(e.mode)));
      if (e.ca) check(64'(dec.addr), 64'(e.addr));
      if (e.nc != 3'd0) check(64'(acnt), 64'(e.nc));
      acnt = 0;
    end
  end

  always @(posedge ref_clk) begin
    if (run) begin
      ce <= ($urandom % 4) != 0;
    end
  end

  // ==========================================
  // program and expectations
  initial begin
    void'($urandom(21));
    n = 8'($urandom);
    q = {2'b01, 6'($urandom)};
    d = 8'($urandom);
    b = 3'($urandom);
    for (int i = 0; i < 4096; i++) begin
      mem.pmem[i] = 8'hf0;
    end
    for (int i = 0; i < 256; i++) begin
      mem.dmem[i] = 8'($urandom);
    end
    mem.dmem[q] = d;
    a = 8'h00;
    z = 1'b0;
    c = 1'b0;
    // interrupt at first fetch, return lands on 0
    wp = 12'h300;
    emit(8'hf2);
    p = 12'h000;
    note(2'd1, m_inh, 8'h00, 1'b0, 3'd0);
    wp = 12'h000;
    emit(8'he2);
    emit(n);
    p = 12'h002;
    a = n;
    z = (n == 8'h00);
    note(2'd2, m_imm, 8'h00, 1'b0, 3'd4);
    emit(8'hc4);
    p = 12'h003;
    note(2'd1, m_short, 8'h80, 1'b1, 3'd4);
    emit(8'he3);
    emit(8'h81);
    emit(q);
    p = 12'h006;
    note(2'd3, m_imm, 8'h81, 1'b1, 3'd4);
    emit(8'hd8);
    p = 12'h007;
    a = d;
    z = (d == 8'h00);
    note(2'd1, m_ind, q, 1'b1, 3'd4);
    emit(8'he0);
    emit(8'h80);
    p = 12'h009;
    a = n;
    z = (n == 8'h00);
    note(2'd2, m_dir, 8'h80, 1'b1, 3'd4);
    emit({5'b10101, b});
    emit(q);
    p = 12'h00b;
    c = d[b];
    note(2'd2, m_bitdir, q, 1'b1, 3'd4);
    // forward branch on carry, both landings jump on to 20h
    emit(8'h65);
    p = c ? 12'h011 : 12'h00c;
    note(2'd1, m_rel, 8'h00, 1'b0, 3'd2);
    emit(8'h80);
    emit(8'h20);
    wp = 12'h011;
    emit(8'h80);
    emit(8'h20);
    p = 12'h020;
    note(2'd2, m_ext, 8'h00, 1'b0, 3'd4);
    wp = 12'h020;
    emit({5'b10111, b});
    emit(q);
    emit(8'h7f);
    p = 12'h0a0;
    c = 1'b1;
    note(2'd3, m_bittst, q, 1'b1, 3'd5);
    wp = 12'h0a0;
    emit(8'h91);
    emit(8'h00);
    // carry is set here: the no-carry branch falls through, then loop back on carry
    emit(8'h50);
    emit(8'h71);
    p = 12'h100;
    note(2'd2, m_ext, 8'h00, 1'b0, 3'd4);
    wp = 12'h100;
    emit(8'hf1);
    p = 12'h0a2;
    note(2'd1, m_inh, 8'h00, 1'b0, 3'd2);
    p = 12'h0a3;
    note(2'd1, m_rel, 8'h00, 1'b0, 3'd2);
    p = 12'h0a2;
    note(2'd1, m_rel, 8'h00, 1'b0, 3'd2);
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    ce <= 1'b1;
    int_req <= 1'b1;
    @(posedge ref_clk);
    int_req <= 1'b0;
    @(posedge ref_clk);
    run <= 1'b1;
    while (expq.size() > 0) begin
      @(posedge ref_clk);
    end
    check(64'(mem.dmem[8'h80]), 64'(n));
    check(64'(mem.dmem[8'h81]), 64'(q));
    check(64'(mem.dmem[q]), 64'(d | (8'h01 << b)));
    check(64'(acks), 64'd1);
    complete_run();
  end
endmodule : tb_top
